// >>> verilog/pds_pkg.sv
// Constants, states and commands of the power-state control block
package pds_pkg;
   // Clock period of the sampling clock
   localparam int CLK_PERIOD_NS = 10;
   // Self-refresh exit delay before a non-read command, in ns (least time)
   localparam int XSNR_NS = 138;
   localparam int XSNR_CYC = (XSNR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Self-refresh exit delay before a read, in clocks
   localparam int XSRD_CYC = 200;
   // Registrations needed at one clock-gate level
   localparam logic [1:0] CKE_MIN_REG = 2'h3;
   // Mode-set delay, in clocks
   localparam logic [7:0] MRD_CYC = 8'h02;
   // Register byte offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_ERROR = 8'h04;
   localparam logic [7:0] OFS_EXIT_CFG = 8'h08;
   localparam logic [7:0] OFS_MODE = 8'h0C;
   // Exit configuration fields and reset value
   localparam int EXIT_FAST_POS = 0;
   localparam int EXIT_SLOW_POS = 8;
   localparam int EXIT_XP_POS = 16;
   localparam logic [23:0] EXIT_CFG_RST = 24'h02_07_02;
   // Status fields
   localparam int ST_STATE_POS = 0;
   localparam int ST_OPEN_POS = 8;
   localparam int ST_NONREAD_POS = 16;
   localparam int ST_READ_POS = 17;
   localparam int ST_TERM_POS = 18;
   localparam int ST_BUSY_POS = 19;
   // Error flag positions
   localparam int ERR_CMD = 0;
   localparam int ERR_BUSY = 1;
   localparam int ERR_SR_OPEN = 2;
   localparam int ERR_PULSE = 3;
   localparam int ERR_XSNR = 4;
   localparam int ERR_READ = 5;
   localparam int ERR_W = 6;
   // Mode register fields
   localparam int MR_BL_POS = 0;
   localparam int MR_CL_POS = 4;
   localparam int MR_WR_POS = 9;
   localparam int MR_SLOW_EXIT_BIT = 12;
   localparam int EMR_AL_POS = 3;
   localparam int EMR_RTT0_BIT = 2;
   localparam int EMR_RTT1_BIT = 6;
   // Power states
   typedef enum logic [1:0] {
      ST_ACTIVE,
      ST_ACT_PD,
      ST_PRE_PD,
      ST_SELF_REF
   } pds_state_e;
   // Decoded commands
   typedef enum logic [2:0] {
      CMD_NOP,
      CMD_ACT,
      CMD_READ,
      CMD_WRITE,
      CMD_PRE,
      CMD_REF,
      CMD_MODE
   } pds_cmd_e;
endpackage : pds_pkg

// >>> verilog/pds_bank_track.sv
// Per-bank open-row tracker with one pending auto precharge
`timescale 1ns/1ns
module pds_bank_track (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire pds_pkg::pds_cmd_e cmd_i,
   input wire logic [2:0] ba_i,
   input wire logic a10_i,
   input wire logic [7:0] ap_delay_i,
   output logic [7:0] open_o
);
   import pds_pkg::*;

   logic [7:0] ap_cnt_q; // Cycles left to the internal precharge
   logic [2:0] ap_bank_q; // Bank waiting for auto precharge
   logic ap_pend_q; // An auto precharge is waiting

   // Auto precharge countdown; a new column command with auto precharge
   // replaces a pending one, as the same bank cannot take two in a row
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ap_cnt_q <= 8'h00;
         ap_bank_q <= 3'h0;
         ap_pend_q <= 1'b0;
      end else if ((cmd_i == CMD_READ || cmd_i == CMD_WRITE) && a10_i) begin
         ap_cnt_q <= ap_delay_i; // RULE_14
         ap_bank_q <= ba_i;
         ap_pend_q <= 1'b1;
      end else if (ap_pend_q) begin
         if (ap_cnt_q == 8'h00) begin
            ap_pend_q <= 1'b0;
         end else begin
            ap_cnt_q <= ap_cnt_q - 8'h01;
         end
      end
   end

   // Open rows: set on activate, cleared by precharge or auto precharge
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         open_o <= 8'h00;
      end else begin
         if (ap_pend_q && ap_cnt_q == 8'h00) begin
            open_o[ap_bank_q] <= 1'b0; // RULE_14
         end
         if (cmd_i == CMD_ACT) begin
            open_o[ba_i] <= 1'b1; // RULE_25
         end else if (cmd_i == CMD_PRE) begin
            // Address bit 10 selects precharge of all banks
            if (a10_i) begin
               open_o <= 8'h00; // RULE_25
            end else begin
               open_o[ba_i] <= 1'b0; // RULE_25
            end
         end
      end
   end
endmodule : pds_bank_track

// >>> verilog/pds_power_ctrl.sv
// Clock-gate driven power-state control with an AHB-Lite register slave
// Overview of operation
// RULE_01 - Transition from previous and current gate plus command
// RULE_02 - Controller uses NOP on power-down edges
// RULE_03 - Idle banks give precharge, else active power-down
// RULE_04 - Gate fall with refresh enters self refresh
// RULE_05 - Controller uses NOP on self-refresh exit edge
// RULE_06 - NOPs during exit delay, reads after 200
// RULE_07 - No entry while operations still in progress
// RULE_08 - Gate held three registrations each level
// RULE_09 - No refresh in power-down; controller limits it
// RULE_10 - Termination ignored for states, off in self refresh
// RULE_11 - Termination input driven while in power-down
// RULE_12 - Unlisted combinations are illegal
// RULE_13 - Entry only after burst fully completes
// RULE_14 - Write auto precharge after recovery, entry follows
// RULE_15 - Precharge power-down allowed one clock after refresh
// RULE_16 - Active power-down allowed one clock after activate
// RULE_17 - Precharge power-down allowed one clock after precharge
// RULE_18 - Mode load only with all banks precharged
// RULE_19 - Entry after mode load waits mode-set delay
// RULE_20 - Clock change only from precharge power-down
// RULE_21 - Gate and termination low two clocks first
// RULE_22 - Stable clocks, DLL reset, termination off relock
// RULE_23 - Reload latency settings after clock change
// RULE_24 - Mode bit 12 picks fast or slow exit
// RULE_25 - Track open row per bank
// RULE_26 - Controller counters block commands until expiry
`timescale 1ns/1ns
module pds_power_ctrl (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic [2:0] ba_i,
   input wire logic [13:0] addr_i,
   input wire logic termination_enable_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   output pds_pkg::pds_state_e power_state_o,
   output logic self_refresh_o,
   output logic termination_on_o,
   output logic nonread_ready_o,
   output logic read_ready_o
);
   import pds_pkg::*;

   // Command decode from the four command strobes
   function automatic pds_cmd_e decode(input logic cs_n, input logic [2:0] rcw);
      if (cs_n) begin
         decode = CMD_NOP; // Deselect acts as NOP
      end else begin
         unique case (rcw)
            3'h3: decode = CMD_ACT;
            3'h5: decode = CMD_READ;
            3'h4: decode = CMD_WRITE;
            3'h2: decode = CMD_PRE;
            3'h1: decode = CMD_REF;
            3'h0: decode = CMD_MODE;
            default: decode = CMD_NOP;
         endcase
      end
   endfunction : decode

   pds_cmd_e cmd; // Command registered at this edge
   pds_state_e state_q; // Current power state
   logic cke_prev_q; // Gate level at the previous edge
   logic [1:0] cke_run_q; // Registrations at the current level
   logic [7:0] open_banks; // Open-row flags per bank
   logic [13:0] mr_q; // Mode register shadow
   logic [13:0] emr_q; // Extended mode register shadow
   logic [23:0] exit_cfg_q; // Exit delays set by software
   logic [7:0] busy_q; // Cycles until burst or mode load completes
   logic [7:0] nonread_cnt_q; // Cycles until non-read commands allowed
   logic [7:0] read_cnt_q; // Cycles until reads allowed
   logic [ERR_W-1:0] err_q; // Sticky protocol error flags
   logic [ERR_W-1:0] err_set; // Error events of this cycle
   logic [7:0] bl_half; // Data clocks of one burst
   logic [7:0] rl; // Read latency in clocks
   logic [7:0] ap_delay; // Delay to internal precharge
   logic fall; // Gate registered high then low
   logic rise; // Gate registered low then high
   logic pd_entry_ok; // Legal power-down entry
   logic sr_entry_ok; // Legal self-refresh entry
   logic exit_ok; // Legal exit from any power-down state
   logic bus_wr_q; // Write data phase pending
   logic [7:0] bus_ofs_q; // Offset of pending write
   logic [7:0] ofs; // Offset of the address phase

   assign cmd = decode(cs_n_i, {ras_n_i, cas_n_i, we_n_i});
   assign bl_half = (mr_q[MR_BL_POS +: 3] == 3'h3) ? 8'h04 : 8'h02;
   assign rl = 8'({5'h00, mr_q[MR_CL_POS +: 3]} + {5'h00, emr_q[EMR_AL_POS +: 3]});
   // Write: write latency + burst + recovery; read: additive latency + burst
   assign ap_delay = (cmd == CMD_WRITE) ?
      8'(rl - 8'h01 + bl_half + {5'h00, mr_q[MR_WR_POS +: 3]} + 8'h01) :
      8'({5'h00, emr_q[EMR_AL_POS +: 3]} + bl_half);
   assign fall = cke_prev_q && !cke_i; // RULE_01
   assign rise = !cke_prev_q && cke_i; // RULE_01
   // Refresh and activate/precharge leave no busy time, so entry is
   // accepted one clock after them
   assign pd_entry_ok = fall && cmd == CMD_NOP && busy_q == 8'h00; // RULE_15 RULE_16 RULE_17
   assign sr_entry_ok = fall && cmd == CMD_REF && busy_q == 8'h00 && open_banks == 8'h00; // RULE_04
   assign exit_ok = rise && cmd == CMD_NOP; // RULE_02 RULE_05
   assign ofs = haddr_i[7:0];

   pds_bank_track u_bank (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .cmd_i(cmd),
      .ba_i(ba_i),
      .a10_i(addr_i[10]),
      .ap_delay_i(ap_delay),
      .open_o(open_banks)
   );

   // Gate history and registration count at the current level
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cke_prev_q <= 1'b1;
         cke_run_q <= CKE_MIN_REG;
      end else begin
         cke_prev_q <= cke_i;
         if (cke_i != cke_prev_q) begin
            cke_run_q <= 2'h1;
         end else if (cke_run_q != CKE_MIN_REG) begin
            cke_run_q <= cke_run_q + 2'h1; // RULE_08
         end
      end
   end

   // Power-state machine; termination input plays no part here
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= ST_ACTIVE;
      end else begin
         unique case (state_q)
            ST_ACTIVE: begin
               if (sr_entry_ok) begin
                  state_q <= ST_SELF_REF; // RULE_04 RULE_10
               end else if (pd_entry_ok) begin
                  // Any open row means active power-down
                  state_q <= (open_banks != 8'h00) ? ST_ACT_PD : ST_PRE_PD; // RULE_03
               end
            end
            ST_ACT_PD, ST_PRE_PD, ST_SELF_REF: begin
               // Gate low keeps the state whatever the command
               if (exit_ok) begin
                  state_q <= ST_ACTIVE; // RULE_01
               end
            end
         endcase
      end
   end

   // Column and mode-load busy time; entry is refused while it runs
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         busy_q <= 8'h00;
      end else if (cmd == CMD_READ) begin
         busy_q <= 8'(rl + bl_half); // RULE_13
      end else if (cmd == CMD_WRITE) begin
         busy_q <= ap_delay; // RULE_13 RULE_14
      end else if (cmd == CMD_MODE) begin
         busy_q <= MRD_CYC - 8'h01; // RULE_19
      end else if (busy_q != 8'h00) begin
         busy_q <= busy_q - 8'h01;
      end
   end

   // Mode shadows caught from mode-load commands
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mr_q <= 14'h0000;
         emr_q <= 14'h0000;
      end else if (cmd == CMD_MODE && open_banks == 8'h00) begin
         // Loads with a bank open are flagged and dropped
         if (ba_i == 3'h0) begin
            mr_q <= addr_i; // RULE_18
         end else if (ba_i == 3'h1) begin
            emr_q <= addr_i;
         end
      end
   end

   // Exit delay counters; reloaded at every exit
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         nonread_cnt_q <= 8'h00;
         read_cnt_q <= 8'h00;
      end else if (state_q == ST_SELF_REF && exit_ok) begin
         nonread_cnt_q <= 8'(XSNR_CYC); // RULE_06
         read_cnt_q <= 8'(XSRD_CYC); // RULE_06
      end else if (state_q != ST_ACTIVE && exit_ok) begin
         nonread_cnt_q <= exit_cfg_q[EXIT_XP_POS +: 8];
         if (state_q == ST_ACT_PD && mr_q[MR_SLOW_EXIT_BIT]) begin
            read_cnt_q <= exit_cfg_q[EXIT_SLOW_POS +: 8]; // RULE_24
         end else if (state_q == ST_ACT_PD) begin
            read_cnt_q <= exit_cfg_q[EXIT_FAST_POS +: 8]; // RULE_24
         end else begin
            read_cnt_q <= exit_cfg_q[EXIT_XP_POS +: 8];
         end
      end else begin
         if (nonread_cnt_q != 8'h00) begin
            nonread_cnt_q <= nonread_cnt_q - 8'h01;
         end
         if (read_cnt_q != 8'h00) begin
            read_cnt_q <= read_cnt_q - 8'h01;
         end
      end
   end

   // Protocol error events seen from the device side
   always_comb begin
      err_set = '0;
      // Gate edge with any command other than NOP, except refresh entry
      err_set[ERR_CMD] = (rise && cmd != CMD_NOP) ||
         (fall && cmd != CMD_NOP && cmd != CMD_REF); // RULE_12
      err_set[ERR_BUSY] = fall && busy_q != 8'h00; // RULE_07
      err_set[ERR_SR_OPEN] = (fall && cmd == CMD_REF && open_banks != 8'h00) ||
         (cmd == CMD_MODE && open_banks != 8'h00); // RULE_04 RULE_18
      err_set[ERR_PULSE] = (cke_i != cke_prev_q) && cke_run_q != CKE_MIN_REG; // RULE_08
      err_set[ERR_XSNR] = state_q == ST_ACTIVE && nonread_cnt_q != 8'h00 &&
         cmd != CMD_NOP; // RULE_06
      err_set[ERR_READ] = cmd == CMD_READ && read_cnt_q != 8'h00; // RULE_06
   end

   // Outputs of the power state; refresh runs only in self refresh
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         power_state_o <= ST_ACTIVE;
         self_refresh_o <= 1'b0;
         termination_on_o <= 1'b0;
         nonread_ready_o <= 1'b1;
         read_ready_o <= 1'b1;
      end else begin
         power_state_o <= state_q;
         self_refresh_o <= state_q == ST_SELF_REF; // RULE_09
         // Termination stays off in self refresh and through its read delay
         termination_on_o <= termination_enable_i && state_q != ST_SELF_REF &&
            read_cnt_q == 8'h00 && (emr_q[EMR_RTT0_BIT] || emr_q[EMR_RTT1_BIT]); // RULE_10
         nonread_ready_o <= nonread_cnt_q == 8'h00;
         read_ready_o <= read_cnt_q == 8'h00;
      end
   end

   // Bus slave: address phase latched, read data prepared for data phase;
   // always zero wait states with an OKAY response
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bus_wr_q <= 1'b0;
         bus_ofs_q <= 8'h00;
         hrdata_o <= 32'h0000_0000;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
         bus_wr_q <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
         bus_ofs_q <= ofs;
         if (hsel_i && hready_i && htrans_i[1] && !hwrite_i) begin
            unique case (ofs)
               OFS_STATUS: hrdata_o <= {12'h000, busy_q != 8'h00, termination_on_o,
                  read_ready_o, nonread_ready_o, open_banks, 6'h00, state_q};
               OFS_ERROR: hrdata_o <= {{(32 - ERR_W){1'b0}}, err_q};
               OFS_EXIT_CFG: hrdata_o <= {8'h00, exit_cfg_q};
               OFS_MODE: hrdata_o <= {2'h0, emr_q, 2'h0, mr_q};
               default: hrdata_o <= 32'h0000_0000; // Unmapped reads as zero
            endcase
         end
      end
   end

   // Software exit delays steer the counters after power-down exits
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         exit_cfg_q <= EXIT_CFG_RST;
      end else if (bus_wr_q && bus_ofs_q == OFS_EXIT_CFG) begin
         exit_cfg_q <= hwdata_i[23:0];
      end
   end

   // Sticky errors, write one to clear; a new event wins over the clear
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         err_q <= '0;
      end else if (bus_wr_q && bus_ofs_q == OFS_ERROR) begin
         err_q <= (err_q & ~hwdata_i[ERR_W-1:0]) | err_set;
      end else begin
         err_q <= err_q | err_set;
      end
   end
endmodule : pds_power_ctrl

// >>> dv/pds_power_ctrl_sva.sv
// Port-level assertions for the power-state control block
`timescale 1ns/1ns
module pds_power_ctrl_sva (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic termination_enable_i,
   input wire pds_pkg::pds_state_e power_state_o,
   input wire logic self_refresh_o,
   input wire logic termination_on_o,
   input wire logic nonread_ready_o,
   input wire logic read_ready_o
);
   import pds_pkg::*;
   // Deselect or NOP on the strobes
   wire nop_c = cs_n_i | (ras_n_i & cas_n_i & we_n_i);
   // Refresh code on the strobes
   wire ref_c = ~cs_n_i & ~ras_n_i & ~cas_n_i & we_n_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // Rise with NOP after three low registrations
   sequence s_exit;
      !$past(cke_i, 3) && !$past(cke_i, 2) && !$past(cke_i) && cke_i && nop_c;
   endsequence
   // Same edge seen from self refresh; state shows two edges late
   sequence s_sr_exit;
      s_exit ##1 power_state_o == ST_SELF_REF;
   endsequence
   a_stay_active: assert property (power_state_o == ST_ACTIVE && $past(cke_i)
      |=> power_state_o == ST_ACTIVE) else $error("left active with gate high");
   a_low_hold: assert property (power_state_o != ST_ACTIVE && !$past(cke_i)
      |=> $stable(power_state_o)) else $error("low state changed with gate low");
   a_legal_exit: assert property (s_exit ##1 power_state_o != ST_ACTIVE
      |=> power_state_o == ST_ACTIVE) else $error("legal exit edge ignored");
   a_bad_exit: assert property (!$past(cke_i) && cke_i && !nop_c
      ##1 power_state_o != ST_ACTIVE |=> $stable(power_state_o))
      else $error("exit taken with a real command");
   a_sr_flag: assert property (self_refresh_o == (power_state_o == ST_SELF_REF))
      else $error("self refresh flag disagrees with state");
   a_sr_cause: assert property ($rose(self_refresh_o) |-> $past(ref_c, 2)
      && !$past(cke_i, 2) && $past(cke_i, 3)) else $error("self refresh without cause");
   a_nonread_wait: assert property (s_sr_exit |-> ##1 (!nonread_ready_o)[*8]
      ##[1:12] nonread_ready_o) else $error("non-read exit delay wrong");
   a_read_wait: assert property (s_sr_exit |-> ##1 (!read_ready_o)[*8]
      ##[180:204] read_ready_o) else $error("read exit delay wrong");
   a_term_gate: assert property (!termination_enable_i |=> !termination_on_o)
      else $error("termination on without enable");
   a_term_sr: assert property (self_refresh_o |-> !termination_on_o)
      else $error("termination on in self refresh");
   c_sr: cover property (power_state_o == ST_SELF_REF);
   c_act_pd: cover property (power_state_o == ST_ACT_PD);
   c_pre_pd: cover property (power_state_o == ST_PRE_PD);
endmodule : pds_power_ctrl_sva
bind pds_power_ctrl pds_power_ctrl_sva u_sva (.clk_i, .rstn_i, .cke_i, .cs_n_i, .ras_n_i,
   .cas_n_i, .we_n_i, .termination_enable_i, .power_state_o, .self_refresh_o,
   .termination_on_o, .nonread_ready_o, .read_ready_o);

// >>> dv/pds_ctrl_model.sv
// Memory controller model driving commands and the clock gate
`timescale 1ns/1ns
module pds_ctrl_model (
   input wire logic clk_i,
   output logic cke_o,
   output logic cs_n_o,
   output logic ras_n_o,
   output logic cas_n_o,
   output logic we_n_o,
   output logic [2:0] ba_o,
   output logic [13:0] addr_o,
   output logic term_o
);
   // Deselect scrambles don't-care lines so stale values are never trusted
   task automatic desel();
      cs_n_o <= 1'b1;
      {ras_n_o, cas_n_o, we_n_o} <= 3'($urandom);
      ba_o <= 3'($urandom);
      addr_o <= 14'($urandom);
   endtask : desel
   // Gate high, termination always at a defined level
   initial begin
      cke_o = 1'b1;
      term_o = 1'b0;
      desel();
   end
   // Gate change under deselect, held for three registrations
   task automatic gate(input logic lvl);
      cke_o <= lvl;
      repeat (3) @(posedge clk_i);
   endtask : gate
   // One command at the next edge; a gate change riding on it is held
   task automatic cmd(input logic [2:0] code, input logic [2:0] ba,
                      input logic [13:0] a, input logic lvl, input logic more = 1'b0);
      logic chg;
      chg = (lvl != cke_o);
      cke_o <= lvl;
      cs_n_o <= 1'b0;
      {ras_n_o, cas_n_o, we_n_o} <= code;
      ba_o <= ba;
      addr_o <= a;
      @(posedge clk_i);
      // A chained command keeps the strobes driven
      if (!more) begin
         desel();
      end
      if (chg) begin
         repeat (2) @(posedge clk_i);
      end
   endtask : cmd
   // Termination request level
   task automatic term(input logic v);
      term_o <= v;
   endtask : term
endmodule : pds_ctrl_model

// >>> dv/testbench.sv
// Self-checking bench for the power-state control block
`timescale 1ns/1ns
module testbench;
   import pds_pkg::*;
   // Strobe codes as ras, cas, we
   localparam logic [2:0] C_MODE = 3'h0;
   localparam logic [2:0] C_REF = 3'h1;
   localparam logic [2:0] C_PRE = 3'h2;
   localparam logic [2:0] C_ACT = 3'h3;
   localparam logic [2:0] C_RD = 3'h5;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic hsel_i = 1'b0;
   logic hwrite_i = 1'b0;
   logic [1:0] htrans_i = 2'h0;
   logic [2:0] hsize_i = 3'h0;
   logic [31:0] haddr_i = 32'h0;
   logic [31:0] hwdata_i = 32'h0;
   logic cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, termination_enable_i;
   logic [2:0] ba_i;
   logic [13:0] addr_i;
   logic [31:0] hrdata_o;
   logic hreadyout_o, hresp_o, self_refresh_o, termination_on_o;
   logic nonread_ready_o, read_ready_o;
   pds_state_e power_state_o;
   wire hready_i = hreadyout_o; // Single slave owns the bus ready
   int err_total = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [31:0] rd, v;
   logic [13:0] mr, extended_mode_register;
   logic [7:0] mask;
   logic [2:0] bk;
   always #5 clk_i = ~clk_i;
   pds_power_ctrl u_dut (.clk_i, .rstn_i, .cke_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i, .ba_i,
      .addr_i, .termination_enable_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
      .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .power_state_o, .self_refresh_o,
      .termination_on_o, .nonread_ready_o, .read_ready_o);
   pds_ctrl_model u_ctrl (.clk_i(clk_i), .cke_o(cke_i), .cs_n_o(cs_n_i), .ras_n_o(ras_n_i),
      .cas_n_o(cas_n_i), .we_n_o(we_n_i), .ba_o(ba_i), .addr_o(addr_i),
      .term_o(termination_enable_i));
   // Status word when no delay runs and termination is off
   function automatic logic [31:0] exp_status(input logic [1:0] st, input logic [7:0] op);
      return {14'h0, 2'h3, op, 6'h0, st};
   endfunction : exp_status
   // Power-down kind that an entry with these open rows gives
   function automatic pds_state_e pd_kind(input logic [7:0] op);
      return (op != 8'h00) ? ST_ACT_PD : ST_PRE_PD;
   endfunction : pd_kind
   // Verdict and end of run
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test
   // Hang guard; the whole run needs well under a thousand clocks
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         stop_test();
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // One single AHB transfer; waits on ready in both phases
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk_i);
      htrans_i <= 2'h2;
      hsel_i <= 1'b1;
      hsize_i <= 3'h2;
      haddr_i <= {24'h0, a};
      hwrite_i <= wr;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hsel_i <= 1'b0;
      hwdata_i <= d;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      q = hrdata_o;
   endtask : bus
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
      bus(1'b0, a, 32'h0, rd);
      chk(n, rd & m, e);
   endtask : rchk
   task automatic st(input pds_state_e e);
      chk("power_state", 32'(power_state_o), 32'(e));
   endtask : st
   initial begin
      rd = $urandom(74);
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      // Reset values, read-only status, unmapped hole, setup word round trip
      rchk("status", OFS_STATUS, '1, exp_status(ST_ACTIVE, 8'h00));
      rchk("exit_cfg", OFS_EXIT_CFG, '1, {8'h00, EXIT_CFG_RST});
      rchk("unmapped", 8'h40, '1, 32'h0);
      v = {8'h00, 24'($urandom)};
      bus(1'b1, OFS_EXIT_CFG, v, rd);
      bus(1'b1, OFS_STATUS, '1, rd);
      rchk("exit_cfg_rw", OFS_EXIT_CFG, '1, v);
      rchk("status_ro", OFS_STATUS, '1, exp_status(ST_ACTIVE, 8'h00));
      bus(1'b1, OFS_EXIT_CFG, {8'h00, EXIT_CFG_RST}, rd);
      // Idle entry, then a rise carrying a real command must be refused
      u_ctrl.gate(1'b0);
      st(pd_kind(8'h00));
      u_ctrl.cmd(C_PRE, 3'h0, 14'h0400, 1'b1);
      st(ST_PRE_PD);
      u_ctrl.gate(1'b0);
      u_ctrl.gate(1'b1);
      st(ST_ACTIVE);
      // Open all banks, enter one clock after the last activate
      mask = 8'h00;
      for (int b = 0; b < 8; b++) begin
         u_ctrl.cmd(C_ACT, 3'(b), 14'($urandom), 1'b1, b < 7);
         mask[b] = 1'b1;
      end
      u_ctrl.gate(1'b0);
      st(pd_kind(mask));
      u_ctrl.gate(1'b1);
      rchk("open_rows", OFS_STATUS, '1, exp_status(ST_ACTIVE, mask));
      // Self refresh with rows open is refused
      u_ctrl.cmd(C_REF, 3'h0, 14'h0, 1'b0);
      st(ST_ACTIVE);
      u_ctrl.gate(1'b1);
      bk = 3'($urandom);
      u_ctrl.cmd(C_PRE, bk, 14'h0, 1'b1);
      mask[bk] = 1'b0;
      rchk("one_closed", OFS_STATUS, 32'h0000FF00, {16'h0, mask, 8'h0});
      // Entry one clock after a read is still inside the burst
      u_ctrl.cmd(C_RD, bk + 3'h1, 14'h0, 1'b1);
      u_ctrl.gate(1'b0);
      st(ST_ACTIVE);
      u_ctrl.gate(1'b1);
      rchk("errors", OFS_ERROR, 32'h0F, 32'h07);
      bus(1'b1, OFS_ERROR, 32'h3F, rd);
      rchk("err_clear", OFS_ERROR, 32'h3F, 32'h0);
      u_ctrl.cmd(C_PRE, 3'h0, 14'h0400, 1'b1);
      u_ctrl.gate(1'b0);
      st(pd_kind(8'h00));
      chk("term_off", 32'(termination_on_o), 32'h0);
      u_ctrl.gate(1'b1);
      // Mode loads, entry once the mode-set delay is met, termination on
      mr = 14'($urandom);
      extended_mode_register = 14'($urandom) | 14'h0004;
      u_ctrl.cmd(C_MODE, 3'h0, mr, 1'b1, 1'b1);
      u_ctrl.cmd(C_MODE, 3'h1, extended_mode_register, 1'b1);
      @(posedge clk_i);
      u_ctrl.gate(1'b0);
      st(ST_PRE_PD);
      u_ctrl.term(1'b1);
      repeat (2) @(posedge clk_i);
      chk("term_pd", 32'(termination_on_o), 32'h1);
      u_ctrl.gate(1'b1);
      rchk("mode", OFS_MODE, 32'h3FFF3FFF, {2'h0, extended_mode_register, 2'h0, mr});
      // Entry one clock after a refresh, then refresh with the gate falling
      u_ctrl.cmd(C_REF, 3'h0, 14'h0, 1'b1);
      u_ctrl.gate(1'b0);
      st(ST_PRE_PD);
      u_ctrl.gate(1'b1);
      u_ctrl.cmd(C_REF, 3'h0, 14'h0, 1'b1, 1'b1);
      u_ctrl.cmd(C_REF, 3'h0, 14'h0, 1'b0);
      st(ST_SELF_REF);
      chk("sr_flag", 32'(self_refresh_o), 32'h1);
      chk("term_sr", 32'(termination_on_o), 32'h0);
      u_ctrl.gate(1'b1);
      chk("nonread_busy", 32'(nonread_ready_o), 32'h0);
      repeat (16) @(posedge clk_i);
      chk("nonread_done", 32'(nonread_ready_o), 32'h1);
      chk("read_busy", 32'(read_ready_o), 32'h0);
      u_ctrl.cmd(C_RD, 3'h0, 14'h0, 1'b1);
      rchk("early_read", OFS_ERROR, 32'h20, 32'h20);
      repeat (200) @(posedge clk_i);
      chk("read_done", 32'(read_ready_o), 32'h1);
      chk("term_back", 32'(termination_on_o), 32'h1);
      stop_test();
   end
endmodule : testbench
